// ==== design/abo_consts.svh ====
// Constants for the accumulator bit operations unit
`ifndef ABO_CONSTS_SVH
`define ABO_CONSTS_SVH
`define ABO_ACC_W        32
`define ABO_WORD_W       16
`define ABO_IDX_W        5
`define ABO_CNT_W        6
`define ABO_SHIFT_MIN    6'h01
`define ABO_SHIFT_MAX    6'h20
`define ABO_ACC_RST      32'h0000_0000
`endif

// ==== design/abo_pkg.sv ====
// Types for the accumulator bit operations unit
package abo_pkg;
  typedef enum logic [2:0]
  {
    ABO_OP_NONE = 3'h0,
    ABO_OP_DECR = 3'h1,
    ABO_OP_SHL  = 3'h2,
    ABO_OP_SHR  = 3'h3,
    ABO_OP_ENC  = 3'h4,
    ABO_OP_DEC  = 3'h5
  } abo_op_e;

  typedef struct packed
  {
    logic          valid;
    abo_op_e       op;
    logic [15:0]   mem_word;
    logic [5:0]    count;
  } abo_req_s;

  typedef struct packed
  {
    logic          mem_we;
    logic [15:0]   mem_word;
    logic          acc_we;
    logic [31:0]   acc;
    logic          zero_result_flag;
    logic          operand_range_flag;
  } abo_rsp_s;
endpackage

// ==== design/abo_unit.sv ====
// Accumulator datapath: decrement, shifts, priority encode, one-hot decode
// Functional notes
// - Decrement writes memory word minus one back
// - Decrement sets zero flag on zero result
// - Flags hold until next affecting operation
// - Shift left 1-32, zero fill, discard
// - Shift right 1-32, zero fill, lost
// - Encode gives index; bit 31 gives 1F
// - Encode of zero or bit0 gives zero
// - Multiple bits: lowest encoded, range flag set
// - Encode result is 5-bit low index
// - Decode sets bit at 5-bit index
// - Decode input above 31 divided by 32
`timescale 1ns/100ps
`default_nettype none
`include "abo_consts.svh"
module abo_unit
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire abo_pkg::abo_req_s req_i,
  input  wire logic [31:0]      acc_i,
  output var  abo_pkg::abo_rsp_s rsp_o
);
  import abo_pkg::*;

  // Decoded requests; a code outside the known set raises none of them
  logic              take_decr;
  logic              take_shl;
  logic              take_shr;
  logic              take_enc;
  logic              take_hot;

  // Datapath results, settled before the edge that stores them
  logic [15:0]       decr_word;
  logic [5:0]        shift_cnt;
  logic [31:0]       shl_val;
  logic [31:0]       shr_val;
  logic [31:0]       low_onehot;
  logic              multi_set;
  wire  [32:0][4:0]  enc_chain;
  logic [4:0]        low_idx;
  logic [31:0]       hot_src;
  logic [4:0]        hot_idx;
  wire  [31:0]       hot_val;

  // Response flops; each concern owns its own process
  logic              mem_we_reg;
  logic [15:0]       mem_word_reg;
  logic              acc_we_reg;
  logic [31:0]       acc_reg;
  logic              zero_flag_reg;
  logic              range_flag_reg;

  always_comb
  begin
    take_decr = 1'b0;
    take_shl  = 1'b0;
    take_shr  = 1'b0;
    take_enc  = 1'b0;
    take_hot  = 1'b0;
    if (req_i.valid)
    begin
      case (req_i.op)
        ABO_OP_DECR:
        begin
          take_decr = 1'b1;
        end
        ABO_OP_SHL:
        begin
          take_shl = 1'b1;
        end
        ABO_OP_SHR:
        begin
          take_shr = 1'b1;
        end
        ABO_OP_ENC:
        begin
          take_enc = 1'b1;
        end
        ABO_OP_DEC:
        begin
          take_hot = 1'b1;
        end
        default:
        begin
          take_decr = 1'b0;
        end
      endcase
    end
  end

  // Borrow out of bit 15 is dropped, so zero wraps to all ones
  assign decr_word = req_i.mem_word - 16'h0001;

  // Counts beyond 32 clamp to 32, which clears the accumulator either way
  assign shift_cnt = (req_i.count > `ABO_SHIFT_MAX) ? `ABO_SHIFT_MAX : req_i.count;
  // A full 32-place shift is forced to zero instead of trusting the shifter width
  // zero-filled left shift
  assign shl_val = (shift_cnt == `ABO_SHIFT_MAX) ? 32'h0000_0000 : acc_i << shift_cnt;
  assign shr_val = (shift_cnt == `ABO_SHIFT_MAX) ? 32'h0000_0000 : acc_i >> shift_cnt;

  // Lowest set bit isolated by the two's complement trick
  assign low_onehot = acc_i & (~acc_i + 32'h0000_0001);
  assign multi_set  = (acc_i & ~low_onehot) != 32'h0000_0000;

  // lowest bit index
  // Only one bit of low_onehot is ever high, so the OR chain never mixes indices
  assign enc_chain[0] = 5'h00;
  for (genvar gi = 0; gi < 32; gi++)
  begin : g_enc
    assign enc_chain[gi + 1] = enc_chain[gi] | (low_onehot[gi] ? 5'(gi) : 5'h00);
  end
  assign low_idx = enc_chain[32];

  // repeated divide by 32
  // Six steps bring any 32-bit value below 32; fewer would leave stray high bits
  always_comb
  begin
    hot_src = acc_i;
    for (int k = 0; k < 6; k++)
    begin
      if (hot_src > 32'h0000_001F)
      begin
        hot_src = hot_src >> `ABO_IDX_W;
      end
    end
  end
  assign hot_idx = hot_src[4:0];

  for (genvar gh = 0; gh < 32; gh++)
  begin : g_hot
    assign hot_val[gh] = (hot_idx == 5'(gh));
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mem_we_reg   <= 1'b0;
      mem_word_reg <= 16'h0000;
    end
    else
    begin
      mem_we_reg <= take_decr;
      if (take_decr)
      begin
        mem_word_reg <= decr_word;
      end
    end
  end

  // Accumulator write, one cycle after the request is taken
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_we_reg <= 1'b0;
      acc_reg    <= `ABO_ACC_RST;
    end
    else
    begin
      acc_we_reg <= take_shl || take_shr || take_enc || take_hot;
      if (req_i.valid)
      begin
        case (req_i.op)
          ABO_OP_SHL:
          begin
            acc_reg <= shl_val;
          end
          ABO_OP_SHR:
          begin
            acc_reg <= shr_val;
          end
          ABO_OP_ENC:
          begin
            acc_reg <= {27'h0, low_idx};
          end
          ABO_OP_DEC:
          begin
            acc_reg <= hot_val;
          end
          // Refused codes and the decrement leave the accumulator alone
          default:
          begin
            acc_reg <= acc_reg;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      zero_flag_reg <= 1'b0;
    end
    else if (take_decr)
    begin
      zero_flag_reg <= (decr_word == 16'h0000);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      range_flag_reg <= 1'b0;
    end
    else if (take_enc)
    begin
      range_flag_reg <= multi_set;
    end
  end

  // The struct only groups flops; no logic sits between them and the pins
  assign rsp_o = '{
    mem_we:             mem_we_reg,
    mem_word:           mem_word_reg,
    acc_we:             acc_we_reg,
    acc:                acc_reg,
    zero_result_flag:   zero_flag_reg,
    operand_range_flag: range_flag_reg
  };
endmodule
`default_nettype wire

// ==== test/abo_seq_model.sv ====
// Sequencer model issuing one operation per call
`timescale 1ns/100ps
`default_nettype none
module abo_seq_model (
  input wire logic ref_clk_i,
  output var abo_pkg::abo_req_s req_o,
  output var logic [31:0] acc_o);
  initial {req_o, acc_o} = '0;
  task automatic issue(input logic [72:0] r);
    @(posedge ref_clk_i) {req_o, acc_o} <= {1'b1, r[72:70], r[53:38], r[37:32], r[69:38]};
    // Idle lines show the inverse so no stale operand looks valid
    @(posedge ref_clk_i) {req_o, acc_o} <= ~{req_o, acc_o};
    #1;
  endtask
endmodule
`default_nettype wire

// ==== test/abo_unit_props.sv ====
// Port assertions for the accumulator unit
`timescale 1ns/100ps
`default_nettype none
module abo_unit_props (
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  input wire abo_pkg::abo_req_s req_i,
  input wire logic [31:0]       acc_i,
  input wire abo_pkg::abo_rsp_s rsp_i);
  wire logic [2:0] op = req_i.valid ? req_i.op : 3'h0;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_decr_word: assert property (op == 3'h1 |=>
    rsp_i.mem_word == $past(req_i.mem_word) - 16'h1) else $error("decrement word");
  a_decr_strobe: assert property (op == 3'h1 |=>
    rsp_i.mem_we && !rsp_i.acc_we) else $error("decrement strobe");
  a_zero_flag: assert property (op == 3'h1 |=>
    rsp_i.zero_result_flag == ($past(req_i.mem_word) == 16'h1)) else $error("zero");
  a_zero_hold: assert property (op != 3'h1 |=>
    $stable(rsp_i.zero_result_flag)) else $error("hold");
  a_shl_acc: assert property (op == 3'h2 |=>
    rsp_i.acc == $past(acc_i) << $past(req_i.count)) else $error("shl");
  a_shr_acc: assert property (op == 3'h3 |=>
    rsp_i.acc == $past(acc_i) >> $past(req_i.count)) else $error("shr");
  a_enc_top: assert property (op == 3'h4 |=>
    rsp_i.acc_we && rsp_i.acc[31:5] == 27'h0) else $error("enc");
  a_enc_lowest: assert property (op == 3'h4 && acc_i != 32'h0 |=>
    (($past(acc_i) >> rsp_i.acc[4:0]) & 32'h1) == 32'h1 &&
    ($past(acc_i) & ((32'h1 << rsp_i.acc[4:0]) - 32'h1)) == 32'h0) else $error("enc low");
  a_enc_zero: assert property (op == 3'h4 && acc_i <= 32'h1 |=>
    rsp_i.acc == 32'h0) else $error("enc zero");
  a_range_flag: assert property (op == 3'h4 |=>
    rsp_i.operand_range_flag == ($countones($past(acc_i)) > 1)) else $error("range");
  a_dec_pos: assert property (op == 3'h5 && acc_i < 32'h20 |=>
    rsp_i.acc == 32'h1 << $past(acc_i)) else $error("dec pos");
  a_dec_hot: assert property (op == 3'h5 |=> $onehot(rsp_i.acc)) else $error("dec");
endmodule
`default_nettype wire

// ==== test/abo_unit_tb_top.sv ====
// Testbench top for the accumulator unit
`timescale 1ns/100ps
`default_nettype none
module abo_unit_tb_top;
  logic ref_clk_i = 1'b0, rst_i = 1'b1;
  logic [31:0] acc;
  abo_pkg::abo_req_s req;
  abo_pkg::abo_rsp_s rsp;
  int miscompares = 0, tests_run = 0;
  logic [72:0] tab [12] = '{{3'h2,32'h8001,6'h2,32'h20004}, {3'h3,32'hFFFFFFFF,6'h20,32'h0},
    {3'h5,32'hF,6'h0,32'h8000}, {3'h4,32'h1,6'h0,32'h0}, {3'h4,32'h0,6'h0,32'h0},
    {3'h1,32'h0,6'h0,32'hFFFF}, {3'h2,32'hFFFFFFFF,6'h20,32'h0},
    {3'h3,32'h80000001,6'h1,32'h40000000}, {3'h4,32'h80000000,6'h0,32'h1F},
    {3'h5,32'h3E0,6'h0,32'h80000000}, {3'h4,32'hC00,6'h0,32'hA}, {3'h1,32'h1,6'h0,32'h0}};
  always #5 ref_clk_i = ~ref_clk_i;
  abo_unit u_abo_unit (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req), .acc_i(acc),
    .rsp_o(rsp));
  abo_seq_model u_abo_seq_model (.ref_clk_i(ref_clk_i), .req_o(req), .acc_o(acc));
  task automatic chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) miscompares++;
    if (s !== e) $display("BAD %s exp %h got %h", n, e, s);
    $display("%s checked", n);
  endtask
  task automatic close_out;
    $display("%0d checks, %0d bad", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (tab[r])
    begin
      u_abo_seq_model.issue(tab[r]);
      chk("out", tab[r][31:0], tab[r][72:70] == 3'h1 ? {16'h0, rsp.mem_word} : rsp.acc);
      chk("strobe", tab[r][72:70] == 3'h1 ? 32'h2 : 32'h1,
        {30'h0, rsp.mem_we, rsp.acc_we});
    end
    chk("flags", 32'h3, {30'h0, rsp.zero_result_flag, rsp.operand_range_flag});
    // A refused code must leave the accumulator and flags alone and raise neither strobe
    u_abo_seq_model.issue({3'h7, 32'h1234_5678, 6'h01, 32'h0});
    chk("refused acc", 32'hA, rsp.acc);
    chk("refused flags", 32'h3, {28'h0, rsp.mem_we, rsp.acc_we,
      rsp.zero_result_flag, rsp.operand_range_flag});
    @(posedge ref_clk_i) rst_i <= 1'b1;
    #1 chk("reset", 32'h0, rsp.acc);
    chk("reset rest", 32'h0, {rsp.mem_word, 12'h0, rsp.mem_we, rsp.acc_we,
      rsp.zero_result_flag, rsp.operand_range_flag});
    @(posedge ref_clk_i) rst_i <= 1'b0;
    u_abo_seq_model.issue({3'h2, 32'h1, 6'h01, 32'h0});
    chk("after reset", 32'h2, rsp.acc);
    close_out;
  end
  // Run needs about thirty-five cycles; a hang stops far later
  initial
  begin
    #5000 miscompares++;
    close_out;
  end
endmodule
bind abo_unit abo_unit_props u_abo_unit_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .req_i(req_i), .acc_i(acc_i), .rsp_i(rsp_o));
`default_nettype wire
